/* hdl/udp_defines.svh */
`ifndef UDP_DEFINES_SVH
`define UDP_DEFINES_SVH
// oversampling: 16 ticks per bit, decision on tick 8
`define UDP_OVS_LAST 4'hF
`define UDP_MID 4'h8
// index of last data bit for 8 and 9 bit words
`define UDP_LAST8 4'h7
`define UDP_LAST9 4'h8
`define UDP_BRK_ZEROS 4'hD
`define UDP_FIFO_DEPTH 3'h4
`define UDP_RST_TXE 1'b1
`define UDP_RST_TXI 1'b1
`define UDP_RST_RXI 1'b1
`define UDP_RST_PIN 1'b1
`endif

/* hdl/udp_pkg.sv */
package udp_pkg;
  typedef enum logic [1:0] {
    UDP_PAR_EVEN = 2'b00,
    UDP_PAR_ODD = 2'b01,
    UDP_PAR_MARK = 2'b10,
    UDP_PAR_SPACE = 2'b11
  } udp_par_t;

  typedef enum logic [2:0] {
    UDP_TX_IDLE = 3'b000,
    UDP_TX_START = 3'b001,
    UDP_TX_DATA = 3'b010,
    UDP_TX_PAR = 3'b011,
    UDP_TX_STOP = 3'b100,
    UDP_TX_BRK = 3'b101
  } udp_txs_t;

  typedef enum logic [2:0] {
    UDP_RX_IDLE = 3'b000,
    UDP_RX_START = 3'b001,
    UDP_RX_DATA = 3'b010,
    UDP_RX_PAR = 3'b011,
    UDP_RX_STOP = 3'b100,
    UDP_RX_WAIT = 3'b101
  } udp_rxs_t;

  typedef struct packed {
    logic [2:0] samp;
    logic level;
    logic noise;
  } udp_vote_t;

  typedef struct packed {
    logic [3:0][8:0] mem;
    logic [1:0] wr;
    logic [1:0] rd;
    logic [2:0] cnt;
    logic [8:0] head;
  } udp_fifo_t;

  typedef struct packed {
    udp_txs_t ts;
    logic [3:0] tsub;
    logic [3:0] tbit;
    logic [8:0] tsh;
    logic tpar;
    logic [8:0] hold;
    logic hfull;
    logic [16:0] bcnt;
    logic out;
    udp_rxs_t rs;
    logic [3:0] rsub;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic rnoise;
    logic rperr;
    logic txe;
    logic txi;
    logic rxa;
    logic rxi;
    logic ovr;
    logic nse;
    logic fer;
    logic per;
    logic arm;
    logic s_txe;
    logic s_txi;
    logic s_ovr;
    logic s_nse;
    logic tint;
    logic rint;
  } udp_top_t;

  // parity bit to send, or expected on receive
  function automatic logic udp_parity(logic [8:0] d, logic nine, udp_par_t t);
    logic x;
    x = ^(nine ? d : {1'b0, d[7:0]});
    case (t)
      UDP_PAR_EVEN: return x;
      UDP_PAR_ODD: return ~x;
      UDP_PAR_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
endpackage

/* hdl/udp_fifo_if.sv */
`timescale 1ns/10ps
interface udp_fifo_if;
  logic push;
  logic [8:0] wdata;
  logic pop;
  logic [2:0] cnt;
  logic [8:0] head;
  modport owner (output push, output wdata, output pop, input cnt, input head);
  modport fifo (input push, input wdata, input pop, output cnt, output head);
endinterface

/* hdl/udp_rx_vote.sv */
`timescale 1ns/10ps
module udp_rx_vote (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic pin,
  output logic level,
  output logic noise
);
  import udp_pkg::*;
  udp_vote_t q, d;
  logic [2:0] s;

  always_comb begin
    d = q;
    s = {q.samp[1:0], pin};
    if (tick) begin
      d.samp = s;
      d.level = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
      d.noise = ~((&s) | ~(|s));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.samp <= 3'h7;
      q.level <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign level = q.level;
  assign noise = q.noise;
endmodule // udp_rx_vote

/* hdl/udp_rx_fifo.sv */
`timescale 1ns/10ps
`include "udp_defines.svh"
module udp_rx_fifo (
  input wire logic clk,
  input wire logic rst_n,
  udp_fifo_if.fifo f
);
  import udp_pkg::*;
  udp_fifo_t q, d;
  logic pu;
  logic po;

  always_comb begin
    d = q;
    pu = f.push & (q.cnt != `UDP_FIFO_DEPTH);
    po = f.pop & (q.cnt != 3'h0);
    if (pu) begin
      d.mem[q.wr] = f.wdata;
      d.wr = q.wr + 2'h1;
    end
    if (po) begin
      d.rd = q.rd + 2'h1;
    end
    d.cnt = q.cnt + {2'h0, pu} - {2'h0, po};
    d.head = d.mem[d.rd];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign f.cnt = q.cnt;
  assign f.head = q.head;
endmodule // udp_rx_fifo

/* hdl/udp_uart_data_path.sv */
`timescale 1ns/10ps
`include "udp_defines.svh"
// Contract
// - transmit frame data least significant bit first
// - nine-bit words take the top bit from tx_bit_eight
// - data writes ignored while tx_empty_flag is low
// - status read then data write clears tx idle flag, and tx empty only when the word goes to the holding register
// - tx_empty_flag set when holding register free; interrupts when enabled
// - busy write waits in holding register; idle write starts at once
// - tx_idle_flag set after stop bits or break frame end
// - break held over divisor plus one clocks while idle makes next frame a break
// - break is start plus 13 zeros, repeats, then stop bits after clear
// - break frames raise no transmit interrupt
// - nine-bit receive stores top bit in rx_bit_eight
// - sixteen times oversampling, three-sample majority, LSB first
// - enabled receiver searches the line for a start bit
// - four-word receive FIFO, available flag and fill count
// - interrupt when FIFO reaches trigger level and enabled
// - data read pops the FIFO; receive available clears once the FIFO is empty
// - word on full FIFO sets overrun, keeps FIFO, interrupts if enabled
// - break received as framing error with zero word, then wait high
// - rx idle low from start detect until stop sampled
// - noise flag rises with word, no own interrupt, sequence clears it
// - framing flag set on low stop bit, cleared by reset or by next word with high stop bit
// - parity flag set on failed check when enabled, cleared by reset or by next word without error
// - two-bit parity type plus parity enable
// - dropping transmit enable aborts the frame and idles the line; holding register and flags keep their values
module udp_uart_data_path (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic baud_tick16,
  input wire logic [15:0] baud_divisor,
  input wire logic transmit_enable,
  input wire logic receive_enable,
  input wire logic word_length_sel,
  input wire logic parity_enable,
  input wire udp_pkg::udp_par_t parity_type_sel,
  input wire logic stop_count_sel,
  input wire logic send_break_ctl,
  input wire logic tx_bit_eight,
  input wire logic tx_empty_int_en,
  input wire logic rx_int_en,
  input wire logic [2:0] rx_trigger_level,
  input wire logic status_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic data_rd,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic [7:0] rx_data,
  output logic rx_bit_eight,
  output logic [2:0] rx_fill_count,
  output logic tx_empty_flag,
  output logic tx_idle_flag,
  output logic rx_avail_flag,
  output logic rx_idle_flag,
  output logic overrun_flag,
  output logic noise_flag,
  output logic framing_flag,
  output logic parity_err_flag,
  output logic tx_int,
  output logic rx_int
);
  import udp_pkg::*;

  udp_top_t q, d;
  udp_fifo_if fl ();
  logic vl;
  logic vn;
  logic done;
  logic push;
  logic full;
  logic wr_ok;
  logic clr_tx;
  logic clr_rx;
  logic can_start;
  logic brk_arm;
  logic [3:0] last;
  logic [8:0] twd;
  logic [2:0] cn;

  // last data bit index for the selected word length
  function automatic logic [3:0] last_index(logic nine);
    return nine ? `UDP_LAST9 : `UDP_LAST8;
  endfunction

  // level 0 behaves as 1; an empty fifo never hits
  function automatic logic hit_trigger(logic [2:0] cnt, logic [2:0] lvl);
    return (cnt != 3'h0) && (cnt >= lvl);
  endfunction

  udp_rx_vote u_vote (
    .clk(clk),
    .rst_n(rst_n),
    .tick(baud_tick16),
    .pin(serial_in_pin),
    .level(vl),
    .noise(vn)
  );

  udp_rx_fifo u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .f(fl.fifo)
  );

  always_comb begin
    d = q;
    done = 1'b0;
    push = 1'b0;
    last = last_index(word_length_sel);
    full = (fl.cnt == `UDP_FIFO_DEPTH);
    twd = {tx_bit_eight & word_length_sel, data_wdata};
    wr_ok = data_wr & q.txe;
    clr_tx = data_wr & q.arm;
    clr_rx = data_rd & q.arm;
    brk_arm = (q.bcnt > ({1'b0, baud_divisor} + 17'h1));
    can_start = (q.ts == UDP_TX_IDLE) & transmit_enable & ~brk_arm & ~q.hfull;

    // break hold timer only runs while the line is idle
    // it stops once armed, so it cannot wrap during a long hold
    if (!send_break_ctl || !transmit_enable) begin
      d.bcnt = 17'h0;
    end else if (q.ts == UDP_TX_IDLE && !brk_arm) begin
      d.bcnt = q.bcnt + 17'h1;
    end

    if (wr_ok) begin
      if (can_start) begin
        d.tsh = twd;
        d.tpar = udp_parity(twd, word_length_sel, parity_type_sel);
        d.ts = UDP_TX_START;
        d.tsub = 4'h0;
        d.out = 1'b0;
      end else begin
        d.hold = twd;
        d.hfull = 1'b1;
      end
    end

    if (!transmit_enable) begin
      d.ts = UDP_TX_IDLE;
      d.out = 1'b1;
    end else begin
      case (q.ts)
        UDP_TX_IDLE: begin
          if (brk_arm) begin
            d.ts = UDP_TX_BRK;
            d.tsub = 4'h0;
            d.tbit = 4'h0;
            d.out = 1'b0;
          end else if (q.hfull) begin
            d.tsh = q.hold;
            d.tpar = udp_parity(q.hold, word_length_sel, parity_type_sel);
            d.hfull = 1'b0;
            d.ts = UDP_TX_START;
            d.tsub = 4'h0;
            d.out = 1'b0;
          end
        end
        default: begin
          if (baud_tick16) begin
            d.tsub = q.tsub + 4'h1;
            if (q.tsub == `UDP_OVS_LAST) begin
              case (q.ts)
                UDP_TX_START: begin
                  d.ts = UDP_TX_DATA;
                  d.tbit = 4'h0;
                  d.out = q.tsh[0];
                end
                UDP_TX_DATA: begin
                  if (q.tbit == last) begin
                    d.tbit = 4'h0;
                    d.ts = parity_enable ? UDP_TX_PAR : UDP_TX_STOP;
                    d.out = parity_enable ? q.tpar : 1'b1;
                  end else begin
                    d.tbit = q.tbit + 4'h1;
                    d.tsh = q.tsh >> 1;
                    d.out = q.tsh[1];
                  end
                end
                UDP_TX_PAR: begin
                  d.ts = UDP_TX_STOP;
                  d.tbit = 4'h0;
                  d.out = 1'b1;
                end
                UDP_TX_STOP: begin
                  if (stop_count_sel && q.tbit == 4'h0) begin
                    d.tbit = 4'h1;
                  end else begin
                    d.ts = UDP_TX_IDLE;
                    done = 1'b1;
                  end
                end
                UDP_TX_BRK: begin
                  if (q.tbit != `UDP_BRK_ZEROS) begin
                    d.tbit = q.tbit + 4'h1;
                  end else if (send_break_ctl) begin
                    d.tbit = 4'h0;
                  end else begin
                    d.ts = UDP_TX_STOP;
                    d.tbit = 4'h0;
                    d.out = 1'b1;
                  end
                end
                default: begin
                  d.ts = UDP_TX_IDLE;
                  d.out = 1'b1;
                end
              endcase
            end
          end
        end
      endcase
    end

    if (!receive_enable) begin
      d.rs = UDP_RX_IDLE;
      d.rxi = 1'b1;
    end else begin
      case (q.rs)
        UDP_RX_IDLE: begin
          // raw pin is enough here: a spike is rejected at the start centre
          if (baud_tick16 && !serial_in_pin) begin
            d.rs = UDP_RX_START;
            d.rsub = 4'h0;
            d.rxi = 1'b0;
            d.rnoise = 1'b0;
            d.rperr = 1'b0;
            d.rsh = 9'h000;
          end
        end
        UDP_RX_WAIT: begin
          // a held-low line must not be mistaken for the next start bit
          if (baud_tick16 && vl) begin
            d.rs = UDP_RX_IDLE;
          end
        end
        default: begin
          if (baud_tick16) begin
            d.rsub = q.rsub + 4'h1;
            if (q.rsub == `UDP_MID) begin
              d.rnoise = q.rnoise | vn;
              case (q.rs)
                UDP_RX_START: begin
                  if (vl) begin
                    d.rs = UDP_RX_IDLE;
                    d.rxi = 1'b1;
                  end else begin
                    d.rs = UDP_RX_DATA;
                    d.rbit = 4'h0;
                  end
                end
                UDP_RX_DATA: begin
                  d.rsh[q.rbit] = vl;
                  if (q.rbit == last) begin
                    d.rs = parity_enable ? UDP_RX_PAR : UDP_RX_STOP;
                  end else begin
                    d.rbit = q.rbit + 4'h1;
                  end
                end
                UDP_RX_PAR: begin
                  d.rperr = vl ^ udp_parity(q.rsh, word_length_sel, parity_type_sel);
                  d.rs = UDP_RX_STOP;
                end
                UDP_RX_STOP: begin
                  // one stop bit is checked whatever stop_count_sel says
                  push = 1'b1;
                  d.rxi = 1'b1;
                  d.fer = ~vl;
                  d.per = q.rperr;
                  d.rs = vl ? UDP_RX_IDLE : UDP_RX_WAIT;
                end
                default: begin
                  d.rs = UDP_RX_IDLE;
                end
              endcase
            end
          end
        end
      endcase
    end

    fl.push = push & ~full;
    fl.wdata = q.rsh;
    // reads of an empty fifo are dropped inside the fifo
    fl.pop = data_rd;
    // next fill count, so flags and count move on the same edge
    cn = fl.cnt + {2'h0, fl.push} - {2'h0, data_rd && fl.cnt != 3'h0};

    // set wins over the clear sequence on every flag
    d.txe = (q.txe & ~(clr_tx & q.s_txe)) | ~d.hfull;
    d.txi = (q.txi & ~(clr_tx & q.s_txi)) | done;
    d.ovr = (q.ovr & ~(clr_rx & q.s_ovr)) | (push & full);
    d.nse = (q.nse & ~(clr_rx & q.s_nse)) | (push & d.rnoise);
    d.rxa = (cn != 3'h0);

    if (status_rd) begin
      d.arm = 1'b1;
      d.s_txe = q.txe;
      d.s_txi = q.txi;
      d.s_ovr = q.ovr;
      d.s_nse = q.nse;
    end else if (data_wr || data_rd) begin
      d.arm = 1'b0;
    end

    // breaks never touch the empty flag, so they raise no transmit interrupt
    d.tint = tx_empty_int_en & d.txe;
    d.rint = rx_int_en & (hit_trigger(cn, rx_trigger_level) | d.ovr);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.out <= `UDP_RST_PIN;
      q.txe <= `UDP_RST_TXE;
      q.txi <= `UDP_RST_TXI;
      q.rxi <= `UDP_RST_RXI;
    end else begin
      q <= d;
    end
  end

  assign serial_out_pin = q.out;
  assign rx_data = fl.head[7:0];
  assign rx_bit_eight = fl.head[8];
  assign rx_fill_count = fl.cnt;
  assign tx_empty_flag = q.txe;
  assign tx_idle_flag = q.txi;
  assign rx_avail_flag = q.rxa;
  assign rx_idle_flag = q.rxi;
  assign overrun_flag = q.ovr;
  assign noise_flag = q.nse;
  assign framing_flag = q.fer;
  assign parity_err_flag = q.per;
  assign tx_int = q.tint;
  assign rx_int = q.rint;
endmodule // udp_uart_data_path

/* verif/udp_line_model.sv */
`timescale 1ns/10ps
module udp_line_model (
  input wire logic clk,
  input wire logic tick,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff tick);
  endtask
  // bit 0 goes first; a low last bit is released to idle high afterwards
  // g picks one bit that gets a single-tick spike inside its vote window
  task automatic send(input logic [11:0] f, input int n, input int g = -1);
    for (int i = 0; i < n; i++) begin
      rx_line <= f[i];
      if (i == g) begin
        ticks(7);
        rx_line <= ~f[i];
        ticks(1);
        rx_line <= f[i];
        ticks(8);
      end else begin
        ticks(16);
      end
    end
    if (!f[n - 1]) begin
      rx_line <= 1'b1;
    end
  endtask
  // samples at bit centres; returns mid last bit so a queued frame is not missed
  task automatic get(output logic [11:0] w, input int n);
    w = 12'hFFF;
    @(negedge tx_line);
    ticks(8);
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        ticks(16);
      end
      w[i] = tx_line;
    end
  endtask
endmodule // udp_line_model

/* verif/udp_uart_data_path_chk.sv */
`timescale 1ns/10ps
module udp_uart_data_path_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic baud_tick16,
  input wire logic transmit_enable,
  input wire logic receive_enable,
  input wire logic send_break_ctl,
  input wire logic tx_empty_int_en,
  input wire logic rx_int_en,
  input wire logic [2:0] rx_trigger_level,
  input wire logic status_rd,
  input wire logic data_wr,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic [2:0] rx_fill_count,
  input wire logic tx_empty_flag,
  input wire logic tx_idle_flag,
  input wire logic rx_avail_flag,
  input wire logic rx_idle_flag,
  input wire logic overrun_flag,
  input wire logic tx_int,
  input wire logic rx_int
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_idle_wr;
    status_rd && tx_idle_flag && tx_empty_flag && transmit_enable
    ##1 !data_wr && transmit_enable
    ##1 data_wr && !status_rd && transmit_enable && !send_break_ctl;
  endsequence
  idle_write_a: assert property (s_idle_wr |=> !tx_idle_flag && tx_empty_flag && !serial_out_pin)
    else $error("idle write did not start at once");
  txe_fall_a: assert property ($fell(tx_empty_flag) |-> $past(data_wr))
    else $error("tx empty fell without a write");
  txi_fall_a: assert property ($fell(tx_idle_flag) |-> $past(data_wr || send_break_ctl))
    else $error("tx idle fell without a write");
  tx_int_a: assert property ($past(tx_empty_int_en) && tx_empty_flag |-> tx_int)
    else $error("tx interrupt missing");
  rx_trig_a: assert property ($past(rx_int_en) && rx_fill_count >= $past(rx_trigger_level)
    && rx_fill_count != 3'h0 |-> rx_int)
    else $error("rx trigger interrupt missing");
  ovr_int_a: assert property (overrun_flag && $past(rx_int_en) |-> rx_int)
    else $error("overrun interrupt missing");
  ovr_full_a: assert property ($rose(overrun_flag) |-> rx_fill_count == 3'h4)
    else $error("overrun without full fifo");
  avail_cnt_a: assert property (rx_avail_flag == (rx_fill_count != 3'h0))
    else $error("available flag disagrees with count");
  rx_start_a: assert property ($fell(rx_idle_flag) |-> $past(baud_tick16 && !serial_in_pin && receive_enable))
    else $error("rx idle fell without a start bit");
  pin_idle_a: assert property (!transmit_enable |=> serial_out_pin)
    else $error("line not idle while transmitter off");
endmodule // udp_uart_data_path_chk

bind udp_uart_data_path udp_uart_data_path_chk chk_i (.*);

/* verif/tb_udp_uart_data_path.sv */
`timescale 1ns/10ps
module tb_udp_uart_data_path;
  import udp_pkg::*;
  logic clk = 1'b0;
  logic rst_n, baud_tick16, transmit_enable, receive_enable, word_length_sel, parity_enable;
  logic stop_count_sel, send_break_ctl, tx_bit_eight, tx_empty_int_en, rx_int_en;
  logic status_rd, data_wr, data_rd, serial_in_pin, serial_out_pin, rx_bit_eight;
  logic tx_empty_flag, tx_idle_flag, rx_avail_flag, rx_idle_flag, overrun_flag;
  logic noise_flag, framing_flag, parity_err_flag, tx_int, rx_int;
  logic [15:0] baud_divisor;
  logic [7:0] data_wdata, rx_data;
  logic [2:0] rx_trigger_level, rx_fill_count;
  udp_par_t parity_type_sel;
  logic [11:0] w, e;
  logic [8:0] d;
  int err_count = 0;
  int num_checks = 0;

  always #5 clk = ~clk;
  // tick every other cycle keeps a bit at 32 clocks
  always @(negedge clk) baud_tick16 <= rst_n & ~baud_tick16;

  udp_uart_data_path dut (.*);
  udp_line_model m (.clk(clk), .tick(baud_tick16), .tx_line(serial_out_pin),
    .rx_line(serial_in_pin));

  task automatic stop_test;
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // op is {status_rd, data_wr, data_rd}; an idle cycle follows each strobe
  task automatic cpu(input logic [2:0] op, input logic [7:0] dat);
    @(negedge clk);
    {status_rd, data_wr, data_rd} = op;
    data_wdata = dat;
    @(negedge clk);
    {status_rd, data_wr, data_rd} = 3'h0;
  endtask
  function automatic logic [11:0] fr(input logic [8:0] dd, input int nb, input logic pe,
    input logic pv);
    logic [11:0] f;
    f = 12'hFFE;
    for (int i = 0; i < nb; i++) f[i + 1] = dd[i];
    if (pe) f[nb + 1] = pv;
    return f;
  endfunction
  function automatic logic pb(input logic [8:0] dd, input udp_par_t t);
    case (t)
      UDP_PAR_EVEN: return ^dd;
      UDP_PAR_ODD: return ~^dd;
      UDP_PAR_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    #500us;
    err_count++;
    stop_test();
  end

  initial begin
    {rst_n, transmit_enable, receive_enable, word_length_sel} = 4'h0;
    {parity_enable, stop_count_sel, send_break_ctl, tx_bit_eight} = 4'h0;
    {tx_empty_int_en, rx_int_en, status_rd, data_wr, data_rd} = 5'h00;
    parity_type_sel = UDP_PAR_EVEN;
    baud_divisor = 16'h0004;
    data_wdata = 8'h00;
    rx_trigger_level = 3'h4;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk(12'({tx_empty_flag, tx_idle_flag, rx_idle_flag, serial_out_pin, rx_fill_count}), 12'h078);
    {transmit_enable, receive_enable, parity_enable, tx_empty_int_en, rx_int_en} = 5'h1F;
    stop_count_sel = 1'b1;
    for (int p = 0; p < 4; p++) begin
      parity_type_sel = udp_par_t'(p);
      d = 9'(8'h51 + 8'(p));
      fork
        m.get(w, 12);
        begin
          cpu(3'h4, 8'h00);
          cpu(3'h2, d[7:0]);
          chk(12'(tx_empty_flag), 12'h001);
        end
      join
      chk(w, fr(d, 8, 1'b1, pb(d, parity_type_sel)));
      repeat (40) @(negedge clk);
      chk(12'(tx_idle_flag), 12'h001);
    end
    {parity_enable, stop_count_sel, word_length_sel, tx_bit_eight} = 4'h3;
    fork
      begin
        m.get(w, 11);
        m.get(e, 11);
      end
      begin
        cpu(3'h4, 8'h00);
        cpu(3'h2, 8'h3C);
        tx_bit_eight = 1'b0;
        cpu(3'h4, 8'h00);
        cpu(3'h2, 8'hC3);
        chk(12'(tx_empty_flag), 12'h000);
        cpu(3'h2, 8'hFF);
      end
    join
    chk(w, fr(9'h13C, 9, 1'b0, 1'b0));
    chk(e, fr(9'h0C3, 9, 1'b0, 1'b0));
    chk(12'(tx_empty_flag), 12'h001);
    repeat (40) @(negedge clk);
    cpu(3'h4, 8'h00);
    cpu(3'h2, 8'h00);
    repeat (60) @(negedge clk);
    transmit_enable = 1'b0;
    @(negedge clk);
    chk(12'(serial_out_pin), 12'h001);
    transmit_enable = 1'b1;
    word_length_sel = 1'b0;
    for (int i = 0; i < 5; i++) begin
      m.send(fr(9'(8'h20 + 8'(i)), 8, 1'b0, 1'b0), 10);
      if (i == 3) chk(12'({rx_int, rx_fill_count}), 12'h00C);
    end
    chk(12'({overrun_flag, rx_avail_flag, rx_fill_count}), 12'h01C);
    cpu(3'h4, 8'h00);
    for (int i = 0; i < 4; i++) begin
      chk(12'(rx_data), 12'(8'h20 + 8'(i)));
      cpu(3'h1, 8'h00);
    end
    chk(12'({overrun_flag, rx_avail_flag}), 12'h000);
    {word_length_sel, parity_enable} = 2'h3;
    parity_type_sel = UDP_PAR_ODD;
    m.send(fr(9'h1A5, 9, 1'b1, ~pb(9'h1A5, UDP_PAR_ODD)), 12);
    chk(12'({parity_err_flag, rx_bit_eight, rx_data}), 12'h3A5);
    cpu(3'h1, 8'h00);
    {word_length_sel, parity_enable} = 2'h0;
    m.send(fr(9'h0F0, 8, 1'b0, 1'b0), 10, 3);
    chk(12'({noise_flag, rx_fill_count, rx_data}), 12'h9F0);
    cpu(3'h4, 8'h00);
    cpu(3'h1, 8'h00);
    chk(12'(noise_flag), 12'h000);
    m.send(12'h000, 12);
    chk(12'({framing_flag, rx_fill_count, rx_data}), 12'h900);
    stop_test();
  end
endmodule // tb_udp_uart_data_path
